// file: verilog/scc_core_timing.sv
/*
 * Instruction cycle sequencer: cycle counts, external data moves with
 * wait states, address-latch strobe, timer tick and code-space fill.
 * Assumes an execution unit on the same clock that supplies branch
 * decisions and data-move operands, and an asynchronous external RAM.
 */
`timescale 1ns/1ns
module scc_core_timing #(
    parameter int CODE_KB = scc_pkg::CODE_KB_MAX
) (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    output logic [15:0] code_addr_o,
    input wire logic [7:0] code_rdata_i,
    input wire logic branch_take_i,
    input wire logic [15:0] branch_target_i,
    input wire logic irq_req_i,
    input wire logic [15:0] irq_vector_i,
    input wire logic [23:0] movx_addr_i,
    input wire logic [7:0] movx_wdata_i,
    input wire logic xram_en_i,
    output logic [7:0] movx_rdata_o,
    output logic movx_rvalid_o,
    input wire logic [7:0] sfr_addr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic sfr_we_i,
    output logic [7:0] sfr_rdata_o,
    output logic ale_o,
    output logic [23:0] ext_addr_o,
    output logic [7:0] ext_data_o,
    output logic ext_data_oe_o,
    input wire logic [7:0] ext_data_i,
    output logic ext_rd_n_o,
    output logic ext_wr_n_o,
    output logic [7:0] opcode_o,
    output logic instr_first_o,
    output logic instr_done_o,
    output logic timer_tick_o,
    output logic user_loadable_region_o
);

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    localparam logic [15:0] UL_BASE = 16'((CODE_KB - scc_pkg::UL_REGION_KB) * 1024);

    // Returns {length, cycles}
    function automatic logic [5:0] decode(input logic [7:0] op);
        logic [5:0] r;
        r = {2'h1, scc_pkg::CYC_ONE};
        if (op == scc_pkg::OP_JMP_IND)
            r = {2'h1, scc_pkg::CYC_JMP_IND};
        else if (op == scc_pkg::OP_RET || op == scc_pkg::OP_RETI)
            r = {2'h1, scc_pkg::CYC_RET};
        else if (op[4:0] == 5'h11 || op[4:0] == 5'h01 || op == 8'h80 || op == 8'h40 ||
                 op == 8'h50 || op == 8'h60 || op == 8'h70 || op[7:3] == 5'h1B)
            r = {2'h2, scc_pkg::CYC_BR2};
        else if (op == 8'h02 || op == 8'h12 || op == 8'h10 || op == 8'h20 || op == 8'h30 ||
                 op == 8'hB4 || op == 8'hB5 || op[7:2] == 6'h2D || op[7:3] == 5'h17 ||
                 op == 8'hD5)
            r = {2'h3, scc_pkg::CYC_BR3};
        return r;
    endfunction

    scc_pkg::scc_state_t state, next_state;
    logic [3:0] cnt, next_cnt, total, next_total, total_new;
    logic [15:0] pc, next_pc, pc_end;
    logic [1:0] len, next_len;
    logic is_irq, next_is_irq, is_mx, next_is_mx, is_wr, next_is_wr;
    logic use_xram, next_use_xram, rd_pend, next_rd_pend, rvalid, next_rvalid;
    logic [23:0] mx_addr, next_mx_addr;
    logic [7:0] mx_wdata, next_mx_wdata, rdata, next_rdata, op, xram_q;
    logic [5:0] dec;
    logic fill, op_movx, first, last, tick;
    logic [2:0] wait_n, next_wait_n;
    logic [7:0] sfr_rdata, next_sfr_rdata, ext_s1, ext_s2;
    logic [7:0] xram [0:scc_pkg::XRAM_BYTES-1];

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        fill = pc >= scc_pkg::FILL_BASE;
        op = fill ? scc_pkg::OP_NOP : code_rdata_i;
        dec = decode(op);
        op_movx = (op[7:5] == 3'h7) && (op[3:2] == 2'h0) && (op[1:0] != 2'h1);
        first = state == scc_pkg::ST_FIRST;
        total_new = irq_req_i ? scc_pkg::CYC_IRQ_CALL :
                    op_movx ? scc_pkg::CYC_MOVX + {1'b0, wait_n} : dec[3:0];
        last = first ? (total_new == scc_pkg::CYC_ONE) : (cnt == total - 4'h1);
        pc_end = (first ? irq_req_i : is_irq) ? irq_vector_i :
                 branch_take_i ? branch_target_i :
                 pc + {14'h0, (first ? dec[5:4] : len)};
        next_state = state;
        next_cnt = cnt;
        next_total = total;
        next_pc = pc;
        next_len = len;
        next_is_irq = is_irq;
        next_is_mx = is_mx;
        next_is_wr = is_wr;
        next_use_xram = use_xram;
        next_mx_addr = mx_addr;
        next_mx_wdata = mx_wdata;
        next_rd_pend = 1'b0;
        next_rvalid = rd_pend;
        next_rdata = rdata;
        if (rd_pend)
            next_rdata = use_xram ? xram_q : ext_s2;
        case (state)
            scc_pkg::ST_FIRST: begin
                next_total = total_new;
                next_len = dec[5:4];
                next_is_irq = irq_req_i;
                next_is_mx = op_movx && !irq_req_i;
                next_is_wr = op[4];
                next_use_xram = xram_en_i && (movx_addr_i < 24'(scc_pkg::XRAM_BYTES));
                next_mx_addr = movx_addr_i;
                next_mx_wdata = movx_wdata_i;
                if (last) begin
                    next_pc = pc_end;
                end else begin
                    next_cnt = 4'h1;
                    next_state = scc_pkg::ST_BODY;
                end
            end
            scc_pkg::ST_BODY: begin
                if (last) begin
                    next_cnt = 4'h0;
                    next_pc = pc_end;
                    next_rd_pend = is_mx && !is_wr;
                    next_state = scc_pkg::ST_FIRST;
                end else begin
                    next_cnt = cnt + 4'h1;
                    if (is_mx && next_cnt == scc_pkg::MOVX_STROBE_START)
                        next_state = scc_pkg::ST_STROBE;
                end
            end
            scc_pkg::ST_STROBE: begin
                next_cnt = cnt + 4'h1;
                if (cnt == total - 4'h2)
                    next_state = scc_pkg::ST_BODY;
            end
            default: begin
                next_state = scc_pkg::ST_FIRST;
                next_cnt = 4'h0;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state <= scc_pkg::ST_FIRST;
            cnt <= 4'h0;
            total <= scc_pkg::CYC_ONE;
            pc <= scc_pkg::PC_RESET;
            len <= 2'h1;
            is_irq <= 1'b0;
            is_mx <= 1'b0;
            is_wr <= 1'b0;
            use_xram <= 1'b0;
            mx_addr <= 24'h000000;
            mx_wdata <= 8'h00;
            rd_pend <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 8'h00;
            tick <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            total <= next_total;
            pc <= next_pc;
            len <= next_len;
            is_irq <= next_is_irq;
            is_mx <= next_is_mx;
            is_wr <= next_is_wr;
            use_xram <= next_use_xram;
            mx_addr <= next_mx_addr;
            mx_wdata <= next_mx_wdata;
            rd_pend <= next_rd_pend;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            tick <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Extended RAM and pin synchroniser
    // ------------------------------------------------------------
    // on-chip extended RAM block
    always_ff @(posedge ref_clk_i) begin
        if (state == scc_pkg::ST_STROBE && use_xram && is_wr)
            xram[mx_addr[scc_pkg::XRAM_AW-1:0]] <= mx_wdata;
        xram_q <= xram[mx_addr[scc_pkg::XRAM_AW-1:0]];
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ext_s1 <= 8'h00;
            ext_s2 <= 8'h00;
        end else begin
            ext_s1 <= ext_data_i;
            ext_s2 <= ext_s1;
        end
    end

    // ------------------------------------------------------------
    // Wait-state register
    // ------------------------------------------------------------
    always_comb begin
        next_wait_n = wait_n;
        if (sfr_we_i && sfr_addr_i == scc_pkg::MOVX_WAIT_OFFSET)
            next_wait_n = sfr_wdata_i[2:0];
        next_sfr_rdata = (sfr_addr_i == scc_pkg::MOVX_WAIT_OFFSET) ? {5'h00, wait_n} : 8'h00;
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wait_n <= scc_pkg::MOVX_WAIT_RESET;
            sfr_rdata <= 8'h00;
        end else begin
            wait_n <= next_wait_n;
            sfr_rdata <= next_sfr_rdata;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // fetch address only to on-chip memory
    assign code_addr_o = pc;
    assign opcode_o = op;
    assign instr_first_o = first;
    assign instr_done_o = last;
    // strobe in first half of first clock
    assign ale_o = first & ref_clk_i;
    assign ext_addr_o = mx_addr;
    assign ext_data_o = mx_wdata;
    assign ext_data_oe_o = is_mx && is_wr && !use_xram && !first;
    assign ext_rd_n_o = !(state == scc_pkg::ST_STROBE && !is_wr && !use_xram);
    assign ext_wr_n_o = !(state == scc_pkg::ST_STROBE && is_wr && !use_xram);
    assign movx_rdata_o = rdata;
    assign movx_rvalid_o = rvalid;
    assign sfr_rdata_o = sfr_rdata;
    assign timer_tick_o = tick;
    assign user_loadable_region_o = (CODE_KB == scc_pkg::UL_MODEL_KB) && (pc >= UL_BASE);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);

    property p_jmp_ind;
        first && op == scc_pkg::OP_JMP_IND && !irq_req_i |-> !last ##1 !last ##1 last;
    endproperty
    a_jmp_ind: assert property (p_jmp_ind) else $error("indirect jump not 3 clocks");

    property p_br2;
        first && op == 8'h80 && !irq_req_i |-> !last ##1 !last ##1 last ##1 first;
    endproperty
    a_br2: assert property (p_br2) else $error("short jump not 3 clocks");

    property p_br3;
        first && op == 8'h12 && !irq_req_i |-> !last [*3] ##1 last;
    endproperty
    a_br3: assert property (p_br3) else $error("long call not 4 clocks");

    property p_nop;
        first && op == scc_pkg::OP_NOP && !irq_req_i && !branch_take_i |->
            last ##1 (pc == $past(pc) + 16'h1);
    endproperty
    a_nop: assert property (p_nop) else $error("no-op not one byte one clock");

    property p_movx_len;
        first && op_movx && !irq_req_i |=> total == scc_pkg::CYC_MOVX + {1'b0, $past(wait_n)};
    endproperty
    a_movx_len: assert property (p_movx_len) else $error("data move length wrong");

    property p_irq;
        first && irq_req_i |-> !last ##1 !last ##1 last ##1 (pc == $past(irq_vector_i));
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt call not 3 clocks");

    property p_tick;
        1'b1 |=> timer_tick_o;
    endproperty
    a_tick: assert property (p_tick) else $error("timer tick missing");

    property p_ale_once;
        (last |=> first) and (!last |=> !first);
    endproperty
    a_ale_once: assert property (p_ale_once) else $error("strobe phase wrong");

    property p_wait_reg;
        sfr_we_i && sfr_addr_i == scc_pkg::MOVX_WAIT_OFFSET |=>
            {5'h00, wait_n} == ($past(sfr_wdata_i) & 8'h07);
    endproperty
    a_wait_reg: assert property (p_wait_reg) else $error("wait register not written");

    property p_fill;
        pc >= scc_pkg::FILL_BASE |-> op == scc_pkg::OP_NOP;
    endproperty
    a_fill: assert property (p_fill) else $error("fill region not no-op");

    property p_xram;
        use_xram |-> ext_rd_n_o && ext_wr_n_o && !ext_data_oe_o;
    endproperty
    a_xram: assert property (p_xram) else $error("on-chip access reached pins");

    property p_hold;
        !ext_rd_n_o && !$past(ext_rd_n_o) |-> $stable(ext_addr_o) && !last;
    endproperty
    a_hold: assert property (p_hold) else $error("address moved during strobe");

    c_movx_wait: cover property (first && op_movx && wait_n == 3'h3 ##1 !first [*6] ##1 first);
    c_irq: cover property (first && irq_req_i);
    c_xram_rd: cover property (use_xram && rvalid);
    c_fill: cover property (fill && last);

endmodule

// file: verilog/scc_pkg.sv
/*
 * Constants, opcodes and state codes for the single-cycle core timing block.
 * Assumes one core clock per machine cycle and a same-clock code memory.
 */
package scc_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] MOVX_WAIT_OFFSET = 8'h9F;
    localparam logic [2:0] MOVX_WAIT_RESET = 3'h0;

    // ------------------------------------------------------------
    // Memory layout
    // ------------------------------------------------------------
    localparam int CODE_KB_MAX = 62;
    localparam int DATA_NV_BYTES = 4096;
    localparam int GP_RAM_BYTES = 256;
    localparam int XRAM_BYTES = 2048;
    localparam int XRAM_AW = 11;
    localparam int EXT_AW = 24;
    localparam int UL_MODEL_KB = 32;
    localparam int UL_REGION_KB = 8;
    localparam logic [15:0] FILL_BASE = 16'hF800;
    localparam logic [15:0] PC_RESET = 16'h0000;

    // ------------------------------------------------------------
    // Opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_NOP = 8'h00;
    localparam logic [7:0] OP_JMP_IND = 8'h73;
    localparam logic [7:0] OP_RET = 8'h22;
    localparam logic [7:0] OP_RETI = 8'h32;

    // ------------------------------------------------------------
    // Cycle counts, in core clocks
    // ------------------------------------------------------------
    localparam logic [3:0] CYC_ONE = 4'h1;
    localparam logic [3:0] CYC_JMP_IND = 4'h3;
    localparam logic [3:0] CYC_BR2 = 4'h3;
    localparam logic [3:0] CYC_BR3 = 4'h4;
    localparam logic [3:0] CYC_RET = 4'h4;
    localparam logic [3:0] CYC_MOVX = 4'h4;
    localparam logic [3:0] CYC_IRQ_CALL = 4'h3;
    localparam logic [3:0] MOVX_STROBE_START = 4'h2;

    typedef enum logic [2:0] {
        ST_FIRST = 3'b001,
        ST_BODY = 3'b010,
        ST_STROBE = 3'b100
    } scc_state_t;

endpackage

// file: tb/scc_sram_model.sv
/*
 * External static RAM on the data-move pins: 256 bytes decoded from the
 * low address byte, read data after a set access time.
 * Assumes active-low strobes from the core and no pull on the data pins.
 */
`timescale 1ns/1ns
module scc_sram_model #(
    parameter int ACCESS_NS = 5
) (
    input wire logic [23:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic oe_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    output logic [7:0] rdata_o
);
    logic [7:0] mem [256];
    logic [7:0] last = 8'h00;

    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i) ^ 8'h5A;
        end
        rdata_o = 8'hFF;
    end
    always @(negedge rd_n_i) begin
        #(ACCESS_NS);
        if (rd_n_i === 1'b0) begin
            last = mem[addr_i[7:0]];
            rdata_o = last;
        end
    end
    // Released pins show no stale byte
    always @(posedge rd_n_i) rdata_o = ~last;
    always @(wr_n_i or wdata_i or oe_i or addr_i) begin
        if (wr_n_i === 1'b0 && oe_i === 1'b1) begin
            mem[addr_i[7:0]] = wdata_i;
        end
    end
endmodule

// file: tb/testbench.sv
/*
 * Bench for the core timing block: cycle counts, strobe, data moves,
 * wait register, fill region and interrupt call.
 * Assumes the RAM model on the data pins and a bench-held code array.
 */
`timescale 1ns/1ns
module testbench;
    logic ref_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic branch_take_i = 1'b0;
    logic irq_req_i = 1'b0;
    logic xram_en_i = 1'b0;
    logic sfr_we_i = 1'b0;
    logic [15:0] branch_target_i = 16'hF7FF;
    logic [15:0] irq_vector_i = 16'h0200;
    logic [23:0] movx_addr_i = 24'h000000;
    logic [7:0] movx_wdata_i = 8'hC3;
    logic [7:0] sfr_addr_i = 8'h00;
    logic [7:0] sfr_wdata_i = 8'h00;
    logic [7:0] code_mem [65536];
    logic [7:0] code_rdata_i, ext_data_i, movx_rdata_o, sfr_rdata_o, ext_data_o, opcode_o;
    logic [15:0] code_addr_o;
    logic [23:0] ext_addr_o;
    logic movx_rvalid_o, ale_o, ext_data_oe_o, ext_rd_n_o, ext_wr_n_o;
    logic instr_first_o, instr_done_o, timer_tick_o, user_loadable_region_o;
    int mismatches = 0;
    int check_count = 0;

    assign code_rdata_i = code_mem[code_addr_o];
    always #10 ref_clk_i = ~ref_clk_i;

    scc_core_timing #(.CODE_KB(32)) uut (
        .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .code_addr_o(code_addr_o),
        .code_rdata_i(code_rdata_i), .branch_take_i(branch_take_i),
        .branch_target_i(branch_target_i), .irq_req_i(irq_req_i),
        .irq_vector_i(irq_vector_i), .movx_addr_i(movx_addr_i),
        .movx_wdata_i(movx_wdata_i), .xram_en_i(xram_en_i), .movx_rdata_o(movx_rdata_o),
        .movx_rvalid_o(movx_rvalid_o), .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i),
        .sfr_we_i(sfr_we_i), .sfr_rdata_o(sfr_rdata_o), .ale_o(ale_o),
        .ext_addr_o(ext_addr_o), .ext_data_o(ext_data_o), .ext_data_oe_o(ext_data_oe_o),
        .ext_data_i(ext_data_i), .ext_rd_n_o(ext_rd_n_o), .ext_wr_n_o(ext_wr_n_o),
        .opcode_o(opcode_o), .instr_first_o(instr_first_o), .instr_done_o(instr_done_o),
        .timer_tick_o(timer_tick_o), .user_loadable_region_o(user_loadable_region_o)
    );
    scc_sram_model ram (
        .addr_i(ext_addr_o), .wdata_i(ext_data_o), .oe_i(ext_data_oe_o),
        .rd_n_i(ext_rd_n_o), .wr_n_i(ext_wr_n_o), .rdata_o(ext_data_i)
    );

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic cyc();
        @(posedge ref_clk_i);
        #5;
    endtask
    task automatic clr();
        for (int i = 0; i < 65536; i++) begin
            code_mem[i] = 8'h00;
        end
    endtask
    task automatic restart();
        @(negedge ref_clk_i);
        rstn_i = 1'b0;
        repeat (2) @(negedge ref_clk_i);
        check(24'(timer_tick_o), 24'h0);
        check(24'({ext_rd_n_o, ext_wr_n_o, ext_data_oe_o}), 24'h6);
        repeat (3) @(negedge ref_clk_i);
        rstn_i = 1'b1;
    endtask
    task automatic wait_at(input logic [15:0] a);
        logic found;
        found = 1'b0;
        for (int i = 0; i < 500 && !found; i++) begin
            cyc();
            check(24'(timer_tick_o), 24'h1);
            found = (instr_first_o === 1'b1 && code_addr_o === a);
        end
        check(24'(found), 24'h1);
    endtask
    task automatic run_instr(input logic [7:0] op, input logic [3:0] cycles);
        int n;
        n = 1;
        check(24'(opcode_o), 24'(op));
        check(24'(ale_o), 24'h1);
        while (instr_done_o !== 1'b1 && n < 20) begin
            cyc();
            n++;
            check(24'(ale_o), 24'h0);
        end
        check(24'(n), 24'(cycles));
        @(negedge ref_clk_i);
        #1;
        check(24'(ale_o), 24'h0);
        cyc();
    endtask
    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk_i);
        sfr_addr_i = a;
        sfr_wdata_i = d;
        sfr_we_i = 1'b1;
        @(negedge ref_clk_i);
        sfr_we_i = 1'b0;
    endtask
    task automatic sfr_read(input logic [7:0] a, input logic [7:0] exp);
        @(negedge ref_clk_i);
        sfr_addr_i = a;
        cyc();
        check(24'(sfr_rdata_o), 24'(exp));
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_register();
        restart();
        sfr_read(8'h9F, 8'h00);
        sfr_write(8'h9F, 8'hFF);
        sfr_read(8'h9F, 8'h07);
        sfr_write(8'h9E, 8'h55);
        sfr_read(8'h9E, 8'h00);
        sfr_read(8'h9F, 8'h07);
        $display("done register");
    endtask
    task automatic t_cycles();
        logic [15:0] tbl [20] = '{16'h0011, 16'h7313, 16'h2214, 16'h3214, 16'h0123,
            16'h1123, 16'h8023, 16'h4023, 16'h5023, 16'h6023, 16'h7023, 16'hD823,
            16'h0234, 16'h1234, 16'h1034, 16'h2034, 16'h3034, 16'hB434, 16'hBF34, 16'hD534};
        logic [15:0] pc;
        clr();
        pc = 16'h0040;
        for (int i = 0; i < 20; i++) begin
            code_mem[pc] = tbl[i][15:8];
            pc = pc + 16'(tbl[i][7:4]);
        end
        restart();
        wait_at(16'h0040);
        pc = 16'h0040;
        for (int i = 0; i < 20; i++) begin
            check(24'(code_addr_o), 24'(pc));
            run_instr(tbl[i][15:8], tbl[i][3:0]);
            pc = pc + 16'(tbl[i][7:4]);
        end
        $display("done cycles");
    endtask
    task automatic t_movx(input logic [7:0] op, input logic [2:0] w, input logic [23:0] a,
        input logic onchip, input logic [7:0] exp);
        int n;
        int lows;
        clr();
        code_mem[16'h0040] = op;
        movx_addr_i = a;
        xram_en_i = onchip;
        restart();
        sfr_write(8'h9F, {5'h00, w});
        wait_at(16'h0040);
        n = 1;
        lows = 0;
        while (instr_done_o !== 1'b1 && n < 20) begin
            cyc();
            n++;
            lows += (ext_rd_n_o === 1'b0 || ext_wr_n_o === 1'b0) ? 1 : 0;
            if (!onchip) check(ext_addr_o, a);
            if (ext_wr_n_o === 1'b0) check(24'({ext_data_oe_o, ext_data_o}), 24'h1C3);
        end
        check(24'(lows), onchip ? 24'h0 : 24'(w) + 24'h1);
        check(24'(n), 24'(w) + 24'h4);
        cyc();
        check(24'(movx_rvalid_o), 24'h0);
        cyc();
        if (!op[4]) check(24'({movx_rvalid_o, movx_rdata_o}), 24'h100 | 24'(exp));
        $display("done move");
    endtask
    task automatic t_fill();
        clr();
        for (int i = 16'hF800; i < 16'hF804; i++) begin
            code_mem[i] = 8'h02;
        end
        code_mem[16'h0040] = 8'h02;
        restart();
        wait_at(16'h0040);
        check(24'(user_loadable_region_o), 24'h0);
        @(negedge ref_clk_i);
        branch_take_i = 1'b1;
        repeat (4) cyc();
        check(24'(code_addr_o), 24'h00F7FF);
        @(negedge ref_clk_i);
        branch_take_i = 1'b0;
        cyc();
        for (int i = 0; i < 4; i++) begin
            check(24'(code_addr_o), 24'h00F800 + 24'(i));
            check(24'(user_loadable_region_o), 24'h1);
            run_instr(8'h00, 4'h1);
        end
        $display("done fill");
    endtask
    task automatic t_irq();
        int n;
        clr();
        restart();
        wait_at(16'h0040);
        @(negedge ref_clk_i);
        irq_req_i = 1'b1;
        #1;
        n = 1;
        while (instr_done_o !== 1'b1 && n < 20) begin
            cyc();
            n++;
        end
        check(24'(n), 24'h3);
        @(negedge ref_clk_i);
        irq_req_i = 1'b0;
        cyc();
        check(24'(code_addr_o), 24'h000200);
        $display("done irq");
    endtask

    initial begin
        clr();
        t_register();
        t_cycles();
        t_movx(8'hF0, 3'h7, 24'h123456, 1'b0, 8'h00);
        t_movx(8'hE0, 3'h0, 24'h123456, 1'b0, 8'hC3);
        t_movx(8'hE0, 3'h7, 24'h0234AB, 1'b0, 8'hF1);
        t_movx(8'hF0, 3'h1, 24'h000123, 1'b1, 8'h00);
        t_movx(8'hE2, 3'h3, 24'h000123, 1'b1, 8'hC3);
        t_fill();
        t_irq();
        give_verdict();
    end
    initial begin
        #400000;
        mismatches++;
        give_verdict();
    end
endmodule
